// file: pkg/wsic_pkg.sv
/*
  Constants and types for the watchdog / sleep / idle controller.
  Assumes a 50 MHz system clock and a 24-bit configuration address space.
*/
package wsic_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS      = 20;
  localparam int POWERON_DELAY_NS   = 10000;
  localparam int POWERON_DELAY_CYC  =
    (POWERON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_DELAY_US   = 64;
  localparam int POWERUP_DELAY_CYC  =
    (POWERUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_DELAY_US       = 20;
  localparam int OST_DELAY_CYC      =
    (OST_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_SETTLE_US      = 20;
  localparam int PLL_SETTLE_CYC     =
    (PLL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W              = 16;

  // ==========================================================
  // watchdog
  localparam int WDOG_CNT_W         = 16;
  localparam int WDOG_PERIOD_TICKS  = 512;

  // ==========================================================
  // configuration words
  localparam logic [23:0] OSC_CFG_ADDR  = 24'hF80000;
  localparam logic [23:0] WDOG_CFG_ADDR = 24'hF80002;
  localparam logic [23:0] BOR_CFG_ADDR  = 24'hF80004;
  localparam logic [23:0] CFG_ERASED    = 24'hFFFFFF;
  localparam int CFG_DATA_W          = 16;
  localparam int WDOG_CFG_EN_BIT     = 15;
  localparam int OSC_SRC_LSB         = 8;
  localparam int PRI_MODE_LSB        = 0;
  localparam int FAIL_MON_EN_BIT     = 14;
  localparam int PWRT_EN_BIT         = 4;

  // ==========================================================
  // reset-control register
  localparam int RC_POR    = 0;
  localparam int RC_BOR    = 1;
  localparam int RC_IDLE   = 2;
  localparam int RC_SLEEP  = 3;
  localparam int RC_WDOG_TIMEOUT_FLAG   = 4;
  localparam int RC_WDOG_SOFT_ENABLE = 5;
  localparam int RC_EXTR   = 7;
  localparam logic [15:0] RC_WR_MASK   = 16'h00BF;
  localparam logic [15:0] RC_POR_VALUE = 16'h0003;

  // ==========================================================
  // oscillator codes
  localparam logic [2:0] OSC_LP   = 3'h0;
  localparam logic [2:0] OSC_FRC  = 3'h1;
  localparam logic [2:0] OSC_SLOW_INTERNAL_RC = 3'h2;
  localparam logic [2:0] OSC_PRI  = 3'h3;
  localparam logic [4:0] PRI_EC   = 5'h0B;
  localparam logic [4:0] PRI_ERC  = 5'h09;
  localparam int PRI_PLL_BIT      = 4;

  typedef enum logic [1:0] {
    WK_RC   = 2'b00,
    WK_XTAL = 2'b01,
    WK_PLL  = 2'b10,
    WK_LP   = 2'b11
  } wsic_wake_kind_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_IDLE  = 3'b001,
    ST_SLEEP = 3'b010,
    ST_DELAY = 3'b011,
    ST_STALL = 3'b100
  } wsic_pwr_state_t;

endpackage : wsic_pkg

// file: rtl/wsic_wdog.sv
/*
  Watchdog counter stepped by edges of the slow internal RC oscillator.
  Assumes the RC clock arrives as an unsynchronised pin.
*/
`timescale 1ns/1ps
`default_nettype none
module wsic_wdog
  import wsic_pkg::*;
#(
  parameter int PERIOD = wsic_pkg::WDOG_PERIOD_TICKS
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic slow_rc_clk_i,
  input  wire logic enable_i,
  input  wire logic clear_i,
  output logic      overflow_o
);
  import wsic_pkg::*;

  typedef struct packed {
    logic [2:0]            sync;
    logic                  lvl;
    logic [WDOG_CNT_W-1:0] cnt;
    logic                  ovf;
  } wsic_wdog_t;

  wsic_wdog_t s_reg;
  wsic_wdog_t s_next;
  logic       tick;

  // ==========================================================
  // counter
  always_comb begin
    s_next      = s_reg;
    s_next.ovf  = 1'b0;
    s_next.sync = {s_reg.sync[1], s_reg.sync[0], slow_rc_clk_i};
    // a rising change counts only once stages two and three agree
    tick = (s_reg.sync[1] == s_reg.sync[2]) && s_reg.sync[2] && !s_reg.lvl;
    if (s_reg.sync[1] == s_reg.sync[2]) begin
      s_next.lvl = s_reg.sync[2];
    end
    if (clear_i || !enable_i) begin
      s_next.cnt = '0;
    end else if (tick) begin
      if (s_reg.cnt == WDOG_CNT_W'(PERIOD - 1)) begin
        s_next.cnt = '0;
        s_next.ovf = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign overflow_o = s_reg.ovf;

  // ==========================================================
  // checks
  clear_zeroes_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    clear_i |=> (s_reg.cnt == '0) && !overflow_o)
    else $error("watchdog count not zero after clear");
  ovf_at_period_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    overflow_o |-> $past(s_reg.cnt) == WDOG_CNT_W'(PERIOD - 1))
    else $error("watchdog overflow at wrong count");

endmodule : wsic_wdog
`default_nettype wire

// file: rtl/wsic_ctrl.sv
/*
  Power controller: watchdog, Sleep and Idle states, wake sequencing,
  reset-control status bits and configuration word read-back.
  Assumes reset and wake requests are one-cycle pulses on clk_sys_i and
  the configuration fuse words are static inputs.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - watchdog advances only on slow internal RC edges
// - configuration enable bit set runs watchdog permanently; erased reads 1
// - enabled watchdog counts to overflow; overflow resets unless in Sleep or Idle
// - clear instruction zeroes count; software clears often enough
// - with configuration bit 0, software enable bit 5 decides
// - overflow in Sleep wakes and sets Sleep and time-out bits
// - power-save operand selects Sleep or Idle
// - Sleep gates CPU and peripheral clocks and stops oscillator
// - Sleep disables clock monitor; slow RC runs when watchdog on
// - Sleep ends on interrupt, any reset or watchdog overflow
// - wake uses current oscillator; power-on/brown-out use fuse fields
// - crystal waits start-up timer, PLL waits lock, plus other delays
// - RC or external clock wake waits power-on delay only
// - low-power crystal kept through Sleep waits power-on delay only
// - interrupt wake branches to handler and sets Sleep bit
// - crystal dead after delays: trap and fast RC, else stall
// - resets wake Sleep; non-power-on sets Sleep bit, power-on clears
// - Idle gates only CPU clock; monitor RC stays on if enabled
// - Idle ends on interrupt or overflow with no delay; resets go through the delay
// - non-power-on reset or interrupt wake sets Idle bit
// - overflow in Idle wakes and sets Idle and time-out bits
// - configuration words are 24 bits, low 16 used, readable
module wsic_ctrl
  import wsic_pkg::*;
#(
  parameter int POWERON_CYC = wsic_pkg::POWERON_DELAY_CYC,
  parameter int POWERUP_CYC = wsic_pkg::POWERUP_DELAY_CYC,
  parameter int OST_CYC     = wsic_pkg::OST_DELAY_CYC,
  parameter int PLL_CYC     = wsic_pkg::PLL_SETTLE_CYC,
  parameter int WDOG_PERIOD = wsic_pkg::WDOG_PERIOD_TICKS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        por_evt_i,
  input  wire logic        bor_evt_i,
  input  wire logic        mclr_evt_i,
  input  wire logic [23:0] osc_cfg_word_i,
  input  wire logic [23:0] wdog_cfg_word_i,
  input  wire logic [23:0] bor_cfg_word_i,
  input  wire logic        tblrd_req_i,
  input  wire logic [23:0] tblrd_addr_i,
  output logic      [23:0] tblrd_data_o,
  output logic             tblrd_valid_o,
  input  wire logic        reset_control_reg_wr_i,
  input  wire logic [15:0] reset_control_reg_wdata_i,
  output logic      [15:0] reset_control_reg_rdata_o,
  input  wire logic        wdog_clear_instr_i,
  input  wire logic        power_save_instr_i,
  input  wire logic        power_save_sleep_i,
  input  wire logic        irq_wake_i,
  input  wire logic        slow_rc_clk_i,
  input  wire logic [2:0]  current_osc_select_i,
  input  wire logic        lp_keep_in_sleep_i,
  input  wire logic        osc_stable_i,
  input  wire logic        pll_lock_i,
  output logic             core_reset_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             osc_run_o,
  output logic             slow_rc_run_o,
  output logic             fail_mon_en_o,
  output logic      [2:0]  osc_select_o,
  output logic             clk_fail_trap_o,
  output logic             irq_take_o,
  output logic      [2:0]  pwr_state_o
);
  import wsic_pkg::*;

  typedef struct packed {
    wsic_pwr_state_t  st;
    logic [23:0]      osc_cfg;
    logic [23:0]      wdog_cfg;
    logic [23:0]      bor_cfg;
    logic             cfg_loaded;
    logic [15:0]      reset_control_reg;
    logic [DLY_W-1:0] dly;
    logic             in_reset;
    logic [2:0]       osc_sel;
    wsic_wake_kind_t  kind;
    logic             wake_irq;
    logic             irq_take;
    logic             trap;
    logic             rd_valid;
    logic [23:0]      rd_data;
  } wsic_ctrl_t;

  localparam wsic_ctrl_t RESET_STATE = '{
    st: ST_DELAY, osc_cfg: CFG_ERASED, wdog_cfg: CFG_ERASED,
    bor_cfg: CFG_ERASED, cfg_loaded: 1'b0, reset_control_reg: RC_POR_VALUE,
    dly: DLY_W'(POWERON_CYC - 1), in_reset: 1'b1, osc_sel: OSC_FRC,
    kind: WK_RC, wake_irq: 1'b0, irq_take: 1'b0, trap: 1'b0,
    rd_valid: 1'b0, rd_data: 24'h000000};

  wsic_ctrl_t s_reg;
  wsic_ctrl_t s_next;
  logic       wdog_en;
  logic       wdog_ovf;
  logic       wdog_clear;
  logic       fail_mon_cfg;
  logic       osc_ok;
  logic       quiet;
  logic [2:0] cfg_osc;
  logic [4:0] cfg_pri;
  wsic_wake_kind_t kind_cfg;
  wsic_wake_kind_t kind_cur;

  // ==========================================================
  // decoding
  function automatic wsic_wake_kind_t wake_kind(input logic [2:0] osc,
                                                input logic [4:0] pri,
                                                input logic       kept);
    if (osc == OSC_LP) begin
      wake_kind = kept ? WK_LP : WK_XTAL;
    end else if (osc != OSC_PRI) begin
      wake_kind = WK_RC;
    end else if (pri[PRI_PLL_BIT]) begin
      wake_kind = WK_PLL;
    end else if (pri == PRI_EC || pri == PRI_ERC) begin
      wake_kind = WK_RC;
    end else begin
      wake_kind = WK_XTAL;
    end
  endfunction : wake_kind

  // delays are summed, which is safe but longer than running them in parallel
  function automatic logic [DLY_W-1:0] delay_for(input wsic_wake_kind_t k,
                                                 input logic pwrt_en);
    logic [DLY_W-1:0] d;
    d = DLY_W'(POWERON_CYC - 1);
    if (k == WK_XTAL || k == WK_PLL) begin
      d = d + DLY_W'(OST_CYC);
      if (pwrt_en) begin
        d = d + DLY_W'(POWERUP_CYC);
      end
      if (k == WK_PLL) begin
        d = d + DLY_W'(PLL_CYC);
      end
    end
    delay_for = d;
  endfunction : delay_for

  assign cfg_osc      = s_reg.osc_cfg[OSC_SRC_LSB +: 3];
  assign cfg_pri      = s_reg.osc_cfg[PRI_MODE_LSB +: 5];
  assign fail_mon_cfg = s_reg.osc_cfg[FAIL_MON_EN_BIT];
  assign kind_cfg     = wake_kind(cfg_osc, cfg_pri, 1'b0);
  assign kind_cur     = wake_kind(current_osc_select_i, cfg_pri,
                                  lp_keep_in_sleep_i && s_reg.st == ST_SLEEP);
  assign wdog_en = s_reg.wdog_cfg[WDOG_CFG_EN_BIT]
                 | s_reg.reset_control_reg[RC_WDOG_SOFT_ENABLE];
  assign osc_ok  = osc_stable_i && (s_reg.kind != WK_PLL || pll_lock_i);
  assign quiet   = !por_evt_i && !bor_evt_i && !mclr_evt_i;
  assign wdog_clear = wdog_clear_instr_i || s_reg.in_reset || !quiet;

  // ==========================================================
  // watchdog
  wsic_wdog #(
    .PERIOD       (WDOG_PERIOD)
  ) u_wdog (
    .clk_sys_i    (clk_sys_i),
    .rst_b_i      (rst_b_i),
    .slow_rc_clk_i(slow_rc_clk_i),
    .enable_i     (wdog_en),
    .clear_i      (wdog_clear),
    .overflow_o   (wdog_ovf)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    logic go;
    logic use_cfg;
    logic rst_go;
    go      = 1'b0;
    use_cfg = 1'b0;
    rst_go  = 1'b0;
    s_next          = s_reg;
    s_next.trap     = 1'b0;
    s_next.irq_take = 1'b0;
    s_next.rd_valid = 1'b0;
    if (!s_reg.cfg_loaded) begin
      s_next.osc_cfg    = osc_cfg_word_i;
      s_next.wdog_cfg   = wdog_cfg_word_i;
      s_next.bor_cfg    = bor_cfg_word_i;
      s_next.cfg_loaded = 1'b1;
    end
    if (tblrd_req_i) begin
      s_next.rd_valid = 1'b1;
      unique case (tblrd_addr_i)
        OSC_CFG_ADDR:  s_next.rd_data = {8'h00, s_reg.osc_cfg[CFG_DATA_W-1:0]};
        WDOG_CFG_ADDR: s_next.rd_data = {8'h00, s_reg.wdog_cfg[CFG_DATA_W-1:0]};
        BOR_CFG_ADDR:  s_next.rd_data = {8'h00, s_reg.bor_cfg[CFG_DATA_W-1:0]};
        default:       s_next.rd_data = 24'h000000;
      endcase
    end
    if (reset_control_reg_wr_i) begin
      s_next.reset_control_reg = (s_reg.reset_control_reg & ~RC_WR_MASK) | (reset_control_reg_wdata_i & RC_WR_MASK);
    end
    // hardware status updates below override a same-cycle software write
    if (por_evt_i) begin
      s_next.reset_control_reg       = RC_POR_VALUE;
      s_next.cfg_loaded = 1'b0;
      go = 1'b1;
      use_cfg = 1'b1;
      rst_go = 1'b1;
    end else if (bor_evt_i) begin
      s_next.reset_control_reg[RC_POR] = 1'b0;
      s_next.reset_control_reg[RC_BOR] = 1'b1;
      if (s_reg.st == ST_SLEEP) s_next.reset_control_reg[RC_SLEEP] = 1'b1;
      if (s_reg.st == ST_IDLE)  s_next.reset_control_reg[RC_IDLE]  = 1'b1;
      go = 1'b1;
      use_cfg = 1'b1;
      rst_go = 1'b1;
    end else if (mclr_evt_i) begin
      s_next.reset_control_reg[RC_EXTR]  = 1'b1;
      s_next.reset_control_reg[RC_WDOG_TIMEOUT_FLAG]  = 1'b0;
      s_next.reset_control_reg[RC_SLEEP] = (s_reg.st == ST_SLEEP);
      s_next.reset_control_reg[RC_IDLE]  = (s_reg.st == ST_IDLE);
      go = 1'b1;
      rst_go = 1'b1;
    end else if (wdog_ovf) begin
      s_next.reset_control_reg[RC_WDOG_TIMEOUT_FLAG] = 1'b1;
      if (s_reg.st == ST_SLEEP) begin
        s_next.reset_control_reg[RC_SLEEP] = 1'b1;
        go = 1'b1;
      end else if (s_reg.st == ST_IDLE) begin
        s_next.reset_control_reg[RC_IDLE] = 1'b1;
        s_next.irq_take = irq_wake_i;
        s_next.st = ST_RUN;
      end else begin
        s_next.reset_control_reg[RC_SLEEP] = 1'b0;
        s_next.reset_control_reg[RC_IDLE]  = 1'b0;
        s_next.reset_control_reg[RC_EXTR]  = 1'b0;
        go = 1'b1;
        rst_go = 1'b1;
      end
    end else if (irq_wake_i && s_reg.st == ST_SLEEP) begin
      s_next.reset_control_reg[RC_SLEEP] = 1'b1;
      s_next.wake_irq = 1'b1;
      go = 1'b1;
    end else if (irq_wake_i && s_reg.st == ST_IDLE) begin
      s_next.reset_control_reg[RC_IDLE] = 1'b1;
      s_next.irq_take = 1'b1;
      s_next.st = ST_RUN;
    end else begin
      unique case (s_reg.st)
        ST_RUN: begin
          if (power_save_instr_i) begin
            s_next.st = power_save_sleep_i ? ST_SLEEP : ST_IDLE;
          end
        end
        ST_IDLE, ST_SLEEP: begin
        end
        ST_DELAY: begin
          if (s_reg.dly != '0) begin
            s_next.dly = s_reg.dly - 1'b1;
          end else if (s_reg.kind == WK_RC || s_reg.kind == WK_LP || osc_ok) begin
            s_next.st = ST_RUN;
          end else if (fail_mon_cfg) begin
            s_next.trap    = 1'b1;
            s_next.osc_sel = OSC_FRC;
            s_next.st      = ST_RUN;
          end else begin
            s_next.st = ST_STALL;
          end
        end
        ST_STALL: begin
          if (osc_ok) s_next.st = ST_RUN;
        end
        default: s_next.st = ST_RUN;
      endcase
      if (s_next.st == ST_RUN && s_reg.st != ST_RUN) begin
        s_next.in_reset = 1'b0;
        s_next.irq_take = s_reg.wake_irq || s_next.irq_take;
        s_next.wake_irq = 1'b0;
      end
    end
    if (go) begin
      s_next.st       = ST_DELAY;
      s_next.kind     = use_cfg ? kind_cfg : kind_cur;
      s_next.osc_sel  = use_cfg ? cfg_osc : current_osc_select_i;
      s_next.dly      = delay_for(s_next.kind, s_reg.bor_cfg[PWRT_EN_BIT]);
      s_next.in_reset = rst_go || s_reg.in_reset;
      if (rst_go) s_next.wake_irq = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign core_reset_o    = s_reg.in_reset;
  assign cpu_clk_en_o    = (s_reg.st == ST_RUN);
  assign periph_clk_en_o = (s_reg.st == ST_RUN) || (s_reg.st == ST_IDLE);
  assign osc_run_o       = (s_reg.st != ST_SLEEP)
                         || (lp_keep_in_sleep_i && s_reg.osc_sel == OSC_LP);
  assign fail_mon_en_o   = fail_mon_cfg && (s_reg.st != ST_SLEEP);
  assign slow_rc_run_o   = wdog_en || fail_mon_en_o;
  assign osc_select_o    = s_reg.osc_sel;
  assign clk_fail_trap_o = s_reg.trap;
  assign irq_take_o      = s_reg.irq_take;
  assign reset_control_reg_rdata_o    = s_reg.reset_control_reg;
  assign tblrd_valid_o   = s_reg.rd_valid;
  assign tblrd_data_o    = s_reg.rd_data;
  assign pwr_state_o     = s_reg.st;

  // ==========================================================
  // checks
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sleep_clocks_off_a: assert property (
    s_reg.st == ST_SLEEP |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clocks running in sleep");
  idle_cpu_only_a: assert property (
    s_reg.st == ST_IDLE |-> !cpu_clk_en_o && periph_clk_en_o && osc_run_o)
    else $error("idle clock gating wrong");
  sleep_rc_run_a: assert property (
    s_reg.st == ST_SLEEP && wdog_en |-> slow_rc_run_o && !fail_mon_en_o)
    else $error("slow rc or monitor wrong in sleep");
  idle_wake_fast_a: assert property (
    s_reg.st == ST_IDLE && irq_wake_i && quiet |=> cpu_clk_en_o && irq_take_o)
    else $error("idle interrupt wake not immediate");
  sleep_wdt_wake_a: assert property (
    s_reg.st == ST_SLEEP && wdog_ovf && quiet |=> !core_reset_o
      && reset_control_reg_rdata_o[RC_SLEEP] && reset_control_reg_rdata_o[RC_WDOG_TIMEOUT_FLAG]
      && s_reg.st == ST_DELAY)
    else $error("watchdog wake from sleep wrong");
  run_wdt_reset_a: assert property (
    s_reg.st == ST_RUN && wdog_ovf && quiet |=> core_reset_o
      && reset_control_reg_rdata_o[RC_WDOG_TIMEOUT_FLAG] && !reset_control_reg_rdata_o[RC_SLEEP])
    else $error("watchdog overflow did not reset");
  idle_wdt_wake_a: assert property (
    s_reg.st == ST_IDLE && wdog_ovf && quiet && !irq_wake_i |=> cpu_clk_en_o
      && reset_control_reg_rdata_o[RC_IDLE] && reset_control_reg_rdata_o[RC_WDOG_TIMEOUT_FLAG] && !core_reset_o)
    else $error("watchdog wake from idle wrong");
  por_status_a: assert property (
    por_evt_i |=> reset_control_reg_rdata_o == RC_POR_VALUE && core_reset_o)
    else $error("power-on status bits wrong");
  rc_wake_delay_a: assert property (
    s_reg.st == ST_SLEEP && irq_wake_i && quiet && !wdog_ovf
      && kind_cur == WK_RC |=> s_reg.dly == DLY_W'(POWERON_CYC - 1))
    else $error("rc wake delay wrong");
  stall_hold_a: assert property (
    s_reg.st == ST_STALL && !osc_ok && quiet && !wdog_ovf
      |=> s_reg.st == ST_STALL && !cpu_clk_en_o)
    else $error("stall released without stable clock");
  cfg_read_a: assert property (
    tblrd_req_i && tblrd_addr_i == WDOG_CFG_ADDR && s_reg.cfg_loaded
      && quiet |=> tblrd_valid_o
      && tblrd_data_o == {8'h00, s_reg.wdog_cfg[CFG_DATA_W-1:0]})
    else $error("configuration read-back wrong");

endmodule : wsic_ctrl
`default_nettype wire

// file: sim/wsic_core_model.sv
/* core-side model: issues watchdog-clear and power-save instructions.
   assumes callers run on the falling edge of clk_sys_i */
`timescale 1ns/1ps
`default_nettype none
module wsic_core_model (
  input  wire logic clk_sys_i,
  output var logic  wdog_clear_o,
  output var logic  psave_o,
  output var logic  psave_sleep_o
);
  // ==========================================================
  // instruction pulses, one cycle wide
  initial begin
    wdog_clear_o  = 1'b0;
    psave_o       = 1'b0;
    psave_sleep_o = 1'b0;
  end
  task automatic clear_wdog();
    wdog_clear_o = 1'b1;
    @(negedge clk_sys_i);
    wdog_clear_o = 1'b0;
  endtask : clear_wdog
  // operand only matters in the cycle the instruction is taken
  task automatic power_save(input logic sleep);
    psave_sleep_o = sleep;
    psave_o       = 1'b1;
    @(negedge clk_sys_i);
    psave_o = 1'b0;
  endtask : power_save
endmodule : wsic_core_model
`default_nettype wire

// file: sim/wsic_ctrl_tb.sv
/* self-checking bench for wsic_ctrl with shortened delay parameters.
   assumes the core model above and a free slow rc clock that can stop */
`timescale 1ns/1ps
`default_nettype none
module wsic_ctrl_tb;
  import wsic_pkg::*;
  localparam int P = 4;
  localparam logic [23:0] OSC_W = 24'h5A0100; // fast rc, monitor off
  localparam logic [23:0] WDT_W = 24'h33701F; // hw watchdog enable off
  localparam logic [23:0] BOR_W = 24'hC3ABCD;
  logic        clk = 1'b0, rst_b = 1'b0, slow_rc = 1'b0, rc_on = 1'b1;
  logic        por = 1'b0, mclr = 1'b0, irq = 1'b0, req = 1'b0;
  logic        bor = 1'b0, xtal_ok = 1'b1;
  logic [2:0]  cur_osc = OSC_FRC;
  logic        rc_wr = 1'b0, crst, cpu_en, per_en, osc_run, rc_run;
  logic        fm_en, trap, itake, vld, clr, ps, ps_sl;
  logic [23:0] addr = 24'h0, rdat;
  logic [15:0] rc_wd = 16'h0, rc;
  logic [2:0]  osel, st;
  int          num_errors = 0, check_count = 0, n;
  always #10 clk = ~clk;
  // stopping this clock shows the watchdog has no other time base
  always #150 if (rc_on) slow_rc = ~slow_rc;
  wsic_core_model core (.clk_sys_i(clk), .wdog_clear_o(clr),
    .psave_o(ps), .psave_sleep_o(ps_sl));
  wsic_ctrl #(.POWERON_CYC(P), .POWERUP_CYC(P), .OST_CYC(P),
    .PLL_CYC(P), .WDOG_PERIOD(P)) uut (
    .clk_sys_i(clk), .rst_b_i(rst_b), .por_evt_i(por), .bor_evt_i(bor),
    .mclr_evt_i(mclr), .osc_cfg_word_i(OSC_W), .wdog_cfg_word_i(WDT_W),
    .bor_cfg_word_i(BOR_W), .tblrd_req_i(req), .tblrd_addr_i(addr),
    .tblrd_data_o(rdat), .tblrd_valid_o(vld), .reset_control_reg_wr_i(rc_wr),
    .reset_control_reg_wdata_i(rc_wd), .reset_control_reg_rdata_o(rc), .wdog_clear_instr_i(clr),
    .power_save_instr_i(ps), .power_save_sleep_i(ps_sl),
    .irq_wake_i(irq), .slow_rc_clk_i(slow_rc),
    .current_osc_select_i(cur_osc), .lp_keep_in_sleep_i(1'b0),
    .osc_stable_i(xtal_ok), .pll_lock_i(1'b1), .core_reset_o(crst),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_run_o(osc_run),
    .slow_rc_run_o(rc_run), .fail_mon_en_o(fm_en), .osc_select_o(osel),
    .clk_fail_trap_o(trap), .irq_take_o(itake), .pwr_state_o(st));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic wr_reset_control_reg(input logic [15:0] v);
    rc_wr = 1'b1;
    rc_wd = v;
    @(negedge clk);
    rc_wr = 1'b0;
  endtask : wr_reset_control_reg
  task automatic rd_cfg(input logic [23:0] a, input logic [23:0] e);
    req  = 1'b1;
    addr = a;
    @(negedge clk);
    chk(vld, 1'b1);
    chk(rdat, e);
  endtask : rd_cfg
  task automatic wait_rst_done();
    n = 0;
    tick(1);
    while (crst !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk(crst, 1'b0);
  endtask : wait_rst_done
  // ==========================================================
  // scenarios
  task automatic t_boot();
    chk(rc, RC_POR_VALUE);
    chk(crst, 1'b1);
    chk(rc_run, 1'b1);
    rst_b = 1'b1;
    wait_rst_done();
    chk(osel, OSC_FRC);
    chk(st, ST_RUN);
  endtask : t_boot
  task automatic t_cfg();
    rd_cfg(OSC_CFG_ADDR, {8'h00, OSC_W[15:0]});
    rd_cfg(WDOG_CFG_ADDR, {8'h00, WDT_W[15:0]});
    rd_cfg(BOR_CFG_ADDR, {8'h00, BOR_W[15:0]});
    rd_cfg(24'hF80006, 24'h000000);
    req = 1'b0;
    chk(rc_run, 1'b0);
  endtask : t_cfg
  task automatic t_idle_irq();
    wr_reset_control_reg(16'h0000);
    core.power_save(1'b0);
    chk(st, ST_IDLE);
    chk({cpu_en, per_en, osc_run}, 3'h3);
    tick(2);
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
    chk(st, ST_RUN);
    chk(itake, 1'b1);
    chk(rc[RC_IDLE], 1'b1);
  endtask : t_idle_irq
  task automatic t_sleep_irq();
    wr_reset_control_reg(16'h0000);
    core.power_save(1'b1);
    chk(st, ST_SLEEP);
    chk({cpu_en, per_en, osc_run, fm_en}, 4'h0);
    irq = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      irq = 1'b0;
      n++;
    end while (st !== ST_RUN && n < 50);
    chk(n, P + 1);
    chk(itake, 1'b1);
    chk(rc[RC_SLEEP], 1'b1);
    chk(osel, OSC_FRC);
  endtask : t_sleep_irq
  task automatic t_wdog();
    wr_reset_control_reg(16'h0020);
    chk(rc_run, 1'b1);
    core.power_save(1'b0);
    n = 0;
    while (st !== ST_RUN && n < 400) begin
      tick(1);
      n++;
    end
    chk({itake, rc[RC_WDOG_TIMEOUT_FLAG], rc[RC_IDLE]}, 3'h3);
    repeat (20) begin
      core.clear_wdog();
      tick(8);
    end
    chk(crst, 1'b0);
    rc_on = 1'b0;
    tick(200);
    chk(crst, 1'b0);
    rc_on = 1'b1;
    n = 0;
    while (crst !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk({crst, rc[RC_WDOG_TIMEOUT_FLAG]}, 2'h3);
    wait_rst_done();
    wr_reset_control_reg(16'h0000);
  endtask : t_wdog
  // crystal wake with monitor off must stall until the crystal runs
  task automatic t_stall();
    cur_osc = OSC_LP;
    xtal_ok = 1'b0;
    core.power_save(1'b1);
    chk(st, ST_SLEEP);
    irq = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      irq = 1'b0;
      n++;
    end while (st === ST_DELAY && n < 50);
    chk(n, 2 * P + 1);
    tick(3);
    chk(st, ST_STALL);
    chk(trap, 1'b0);
    chk(cpu_en, 1'b0);
    chk(osel, OSC_LP);
    xtal_ok = 1'b1;
    @(negedge clk);
    chk(st, ST_RUN);
    chk(itake, 1'b1);
    cur_osc = OSC_FRC;
  endtask : t_stall
  task automatic t_resets();
    core.power_save(1'b1);
    mclr = 1'b1;
    @(negedge clk);
    mclr = 1'b0;
    wait_rst_done();
    chk({rc[RC_EXTR], rc[RC_SLEEP]}, 2'h3);
    por = 1'b1;
    @(negedge clk);
    por = 1'b0;
    wait_rst_done();
    chk(rc, RC_POR_VALUE);
    core.power_save(1'b0);
    cur_osc = OSC_SLOW_INTERNAL_RC;
    bor = 1'b1;
    @(negedge clk);
    bor = 1'b0;
    wait_rst_done();
    chk({rc[RC_BOR], rc[RC_POR], rc[RC_IDLE]}, 3'h5);
    chk(osel, OSC_FRC);
    cur_osc = OSC_FRC;
  endtask : t_resets
  // ==========================================================
  // sequence, watchdog and verdict
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    tick(3);
    t_boot();
    t_cfg();
    t_idle_irq();
    t_sleep_irq();
    t_wdog();
    t_stall();
    t_resets();
    finish_test();
  end
  initial begin
    #200us;
    num_errors++;
    finish_test();
  end
endmodule : wsic_ctrl_tb
`default_nettype wire
